// ==== include/ebp_pkg.sv ====
/*
  package for the external bus cycle sequencer: register map, field
  positions, reset values, phase encodings and carrier structs.
  assumes a 32-bit axi4-lite register bus and a 40 MHz system clock.
*/
package ebp_pkg;
  // number of chip selects
  localparam int NUM_CS = 4;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING0 = 8'h04;
  localparam logic [7:0] OFS_REQ_ADDR = 8'h14;
  localparam logic [7:0] OFS_REQ_DATA = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_RD_DATA = 8'h20;

  // ctrl register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_BHE = 2;
  localparam int CTRL_CS_LSB = 4;

  // phase_timing_config fields
  localparam int TC_AB_LSB = 0;
  localparam int TC_AB_EXT_LSB = 1;
  localparam int TC_CMD_LSB = 3;
  localparam int TC_WST_LSB = 5;
  localparam int TC_ACC_LSB = 6;
  localparam int TC_HOLD_LSB = 11;
  localparam int TC_MUX = 13;
  localparam int TC_RDY_EN = 14;
  localparam int TC_RDY_POL = 15;
  localparam int TC_RDY_ASYNC = 16;
  localparam logic [31:0] TC_RESET = 32'h0000_07C1;

  // status fields
  localparam int ST_BUSY = 0;
  localparam int ST_PHASE_LSB = 4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_CMD, PH_WST, PH_ACC, PH_RDY, PH_HOLD
  } ebp_phase_t;

  // one decoded phase_timing_config
  typedef struct packed {
    logic [0:0] ab;
    logic [1:0] ab_ext;
    logic [1:0] cmd;
    logic [0:0] wst;
    logic [4:0] acc;
    logic [1:0] hold;
    logic multiplexed_mode;
    logic rdy_en;
    logic rdy_pol;
    logic rdy_async;
  } ebp_timing_t;

  // external bus pins
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [NUM_CS-1:0] cs_n;
    logic ale;
    logic bhe_n;
    logic rd_n;
    logic wr_n;
    logic [DATA_W-1:0] dout;
    logic doe;
  } ebp_pins_t;
endpackage

// ==== verilog/ebp_sync.sv ====
/*
  three-stage synchroniser with agreement filter for a pin input.
  assumes the input may change at any time relative to clk.
*/
`timescale 1ns/100ps
module ebp_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;

  // shift chain; s1 feeds only s2
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // level follows once stages two and three agree
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s3_ff;
    end
  end

  assign level = level_ff;
endmodule // ebp_sync

// ==== verilog/ebp_timer.sv ====
/*
  phase length down-counter: loads a step count, flags the last step.
  assumes the sequencer loads it on each phase entry.
*/
`timescale 1ns/100ps
module ebp_timer #(
  parameter int CNT_W = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // load and status
  input wire logic load,
  input wire logic [CNT_W-1:0] steps,
  output logic last
);
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;

  if (CNT_W < 2) begin : g_bad_w
    $error("ebp_timer: CNT_W too small");
  end

  // remaining steps minus one
  assign nxt_cnt = load ? steps - CNT_W'(1) :
                   (cnt_ff != '0) ? cnt_ff - CNT_W'(1) : cnt_ff;
  assign last = (cnt_ff == '0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // ebp_timer

// ==== verilog/ebp_seq.sv ====
/*
  external bus cycle sequencer with axi4-lite register slave.
  assumes clk at 40 MHz, one timing step per clock, ready from a pin.
*/
// Overview of operation
// - every cycle runs address, command, write/tristate, access, hold in order, skipping zero-length phases
// - phase lengths come from per-chip-select programmable timing registers
// - with ready enabled, external ready may stretch the access phase
// - address setup lasts one or two timing steps as programmed
// - a changed address window adds zero to three setup steps
// - command delay zero to three steps, write setup/tristate zero or one
// - access phase lasts one to thirty-two programmed steps before ready
// - hold phase lasts zero to three steps after strobe ends
// - read data captured on the edge ending read strobe and address
// - address change after strobe end does not disturb captured data
// - ready inactive inserts a wait step, active ends the access phase
// - ready polarity selectable; async mode adds synchroniser and wait step
`timescale 1ns/100ps
module ebp_seq #(
  parameter int NUM_CS = ebp_pkg::NUM_CS
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // external bus
  output ebp_pkg::ebp_pins_t bus,
  input wire logic [ebp_pkg::DATA_W-1:0] bus_din,
  input wire logic ready_pin
);
  if (NUM_CS < 1 || NUM_CS > ebp_pkg::NUM_CS) begin : g_bad_cs
    $error("ebp_seq: bad NUM_CS");
  end

  // registers
  logic [31:0] tcfg_ff [NUM_CS];
  logic [3:0] ctrl_ff;
  logic [1:0] cs_sel_ff;
  logic [ebp_pkg::ADDR_W-1:0] req_addr_ff;
  logic [ebp_pkg::DATA_W-1:0] req_data_ff;
  logic [ebp_pkg::DATA_W-1:0] rd_data_ff;
  logic go_ff;
  ebp_pkg::ebp_phase_t ph_ff;
  ebp_pkg::ebp_phase_t nxt_ph;
  logic [1:0] cur_cs_ff;
  logic [1:0] last_cs_ff;
  logic last_valid_ff;
  logic wr_cyc_ff;
  ebp_pkg::ebp_timing_t t_ff;
  ebp_pkg::ebp_pins_t pins_ff;
  ebp_pkg::ebp_pins_t nxt_pins;
  logic awdone_ff;
  logic wdone_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic bvalid_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [1:0] bresp_ff;

  // decoded timing of the selected chip select
  ebp_pkg::ebp_timing_t t_sel;
  logic [31:0] tsel_raw;
  assign tsel_raw = tcfg_ff[cs_sel_ff];
  assign t_sel.ab = tsel_raw[ebp_pkg::TC_AB_LSB +: 1];
  assign t_sel.ab_ext = tsel_raw[ebp_pkg::TC_AB_EXT_LSB +: 2];
  assign t_sel.cmd = tsel_raw[ebp_pkg::TC_CMD_LSB +: 2];
  assign t_sel.wst = tsel_raw[ebp_pkg::TC_WST_LSB +: 1];
  assign t_sel.acc = tsel_raw[ebp_pkg::TC_ACC_LSB +: 5];
  assign t_sel.hold = tsel_raw[ebp_pkg::TC_HOLD_LSB +: 2];
  assign t_sel.multiplexed_mode = tsel_raw[ebp_pkg::TC_MUX];
  assign t_sel.rdy_en = tsel_raw[ebp_pkg::TC_RDY_EN];
  assign t_sel.rdy_pol = tsel_raw[ebp_pkg::TC_RDY_POL];
  assign t_sel.rdy_async = tsel_raw[ebp_pkg::TC_RDY_ASYNC];

  // ready input: async path synchronised, sync path registered once
  logic rdy_sync;
  logic rdy_reg_ff;
  logic rdy_raw;
  logic rdy_act;
  ebp_sync u_rdy_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin(ready_pin),
    .level(rdy_sync)
  );
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) rdy_reg_ff <= 1'b0;
    else rdy_reg_ff <= ready_pin;
  end
  assign rdy_raw = t_ff.rdy_async ? rdy_sync : rdy_reg_ff;
  assign rdy_act = rdy_raw ~^ t_ff.rdy_pol;

  // phase timer
  logic tm_load;
  logic [5:0] tm_steps;
  logic tm_last;
  ebp_timer #(.CNT_W(6)) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tm_load),
    .steps(tm_steps),
    .last(tm_last)
  );

  // phase lengths
  logic win_change;
  logic [5:0] len_ab;
  logic [5:0] len_cmd;
  logic [5:0] len_wst;
  logic [5:0] len_acc;
  logic [5:0] len_hold;
  assign win_change = !last_valid_ff || (last_cs_ff != cs_sel_ff);
  assign len_ab = 6'(t_sel.ab) + 6'd1 + (win_change ? 6'(t_sel.ab_ext) : 6'd0);
  assign len_cmd = 6'(t_ff.cmd);
  assign len_wst = 6'(t_ff.wst);
  assign len_acc = 6'(t_ff.acc) + 6'd1;
  assign len_hold = 6'(t_ff.hold);

  // phase sequencing, fixed order; zero-length phases are skipped
  logic ph_done;
  logic start;
  logic acc_end;
  logic rdy_wait;
  assign start = (ph_ff == ebp_pkg::PH_IDLE) && go_ff;
  assign ph_done = tm_last;
  // async ready forces at least one wait step before being used
  assign rdy_wait = t_ff.rdy_en && (!rdy_act || (t_ff.rdy_async && ph_ff == ebp_pkg::PH_ACC));
  assign acc_end = ph_done && !rdy_wait;

  always_comb begin
    nxt_ph = ph_ff;
    tm_load = 1'b0;
    tm_steps = 6'd0;
    unique case (ph_ff)
      ebp_pkg::PH_IDLE: if (start) begin
        nxt_ph = ebp_pkg::PH_ADDR;
        tm_load = 1'b1;
        tm_steps = len_ab;
      end
      ebp_pkg::PH_ADDR: if (ph_done) begin
        if (len_cmd != 6'd0) begin
          nxt_ph = ebp_pkg::PH_CMD;
          tm_steps = len_cmd;
        end else if (len_wst != 6'd0) begin
          nxt_ph = ebp_pkg::PH_WST;
          tm_steps = len_wst;
        end else begin
          nxt_ph = ebp_pkg::PH_ACC;
          tm_steps = len_acc;
        end
        tm_load = 1'b1;
      end
      ebp_pkg::PH_CMD: if (ph_done) begin
        if (len_wst != 6'd0) begin
          nxt_ph = ebp_pkg::PH_WST;
          tm_steps = len_wst;
        end else begin
          nxt_ph = ebp_pkg::PH_ACC;
          tm_steps = len_acc;
        end
        tm_load = 1'b1;
      end
      ebp_pkg::PH_WST: if (ph_done) begin
        nxt_ph = ebp_pkg::PH_ACC;
        tm_load = 1'b1;
        tm_steps = len_acc;
      end
      ebp_pkg::PH_ACC, ebp_pkg::PH_RDY: if (acc_end) begin
        nxt_ph = (len_hold != 6'd0) ? ebp_pkg::PH_HOLD : ebp_pkg::PH_IDLE;
        tm_load = (len_hold != 6'd0);
        tm_steps = len_hold;
      end else if (ph_done) begin
        nxt_ph = ebp_pkg::PH_RDY;
      end
      ebp_pkg::PH_HOLD: if (ph_done) begin
        nxt_ph = ebp_pkg::PH_IDLE;
      end
      default: nxt_ph = ebp_pkg::PH_IDLE;
    endcase
  end

  // pin values per phase
  logic in_cyc;
  logic strobe_ph;
  logic data_ph;
  assign in_cyc = (nxt_ph != ebp_pkg::PH_IDLE);
  assign strobe_ph = (nxt_ph == ebp_pkg::PH_ACC) || (nxt_ph == ebp_pkg::PH_RDY);
  assign data_ph = wr_cyc_ff && ((nxt_ph == ebp_pkg::PH_WST) || strobe_ph
                   || (nxt_ph == ebp_pkg::PH_HOLD));
  always_comb begin
    nxt_pins = pins_ff;
    nxt_pins.cs_n = '1;
    if (in_cyc && !start) nxt_pins.cs_n[cur_cs_ff] = 1'b0;
    if (start) nxt_pins.cs_n[cs_sel_ff] = 1'b0;
    if (start) nxt_pins.addr = req_addr_ff;
    nxt_pins.ale = start && t_sel.multiplexed_mode;
    nxt_pins.bhe_n = !(in_cyc && (start ? ctrl_ff[ebp_pkg::CTRL_BHE] : !pins_ff.bhe_n));
    nxt_pins.rd_n = !(strobe_ph && !wr_cyc_ff);
    nxt_pins.wr_n = !(strobe_ph && wr_cyc_ff);
    // mux: address on shared lines during setup, floated in read tristate
    if (start && t_sel.multiplexed_mode) begin
      nxt_pins.dout = req_addr_ff[ebp_pkg::DATA_W-1:0];
      nxt_pins.doe = 1'b1;
    end else if (data_ph) begin
      nxt_pins.dout = req_data_ff;
      nxt_pins.doe = 1'b1;
    end else begin
      nxt_pins.doe = t_ff.multiplexed_mode && (nxt_ph == ebp_pkg::PH_ADDR || nxt_ph == ebp_pkg::PH_CMD)
                     && !start ? pins_ff.doe : 1'b0;
    end
  end
  assign bus = pins_ff;

  // capture read data on the edge that raises the read strobe
  logic rd_end;
  assign rd_end = !pins_ff.rd_n && nxt_pins.rd_n;

  // sequencer state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ph_ff <= ebp_pkg::PH_IDLE;
      pins_ff <= '{addr: '0, cs_n: '1, ale: 1'b0, bhe_n: 1'b1, rd_n: 1'b1,
                   wr_n: 1'b1, dout: '0, doe: 1'b0};
      cur_cs_ff <= 2'd0;
      last_cs_ff <= 2'd0;
      last_valid_ff <= 1'b0;
      wr_cyc_ff <= 1'b0;
      t_ff <= '0;
      rd_data_ff <= '0;
    end else begin
      ph_ff <= nxt_ph;
      pins_ff <= nxt_pins;
      if (start) begin
        cur_cs_ff <= cs_sel_ff;
        last_cs_ff <= cs_sel_ff;
        last_valid_ff <= 1'b1;
        wr_cyc_ff <= ctrl_ff[ebp_pkg::CTRL_WRITE];
        t_ff <= t_sel;
      end
      if (rd_end) rd_data_ff <= bus_din;
    end
  end

  // axi4-lite write channel
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic busy;
  assign busy = (ph_ff != ebp_pkg::PH_IDLE) || go_ff;
  assign s_axi_awready = !awdone_ff && !bvalid_ff;
  assign s_axi_wready = !wdone_ff && !bvalid_ff;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (awdone_ff || aw_take) && (wdone_ff || w_take);
  assign wr_addr = aw_take ? s_axi_awaddr : awaddr_ff;
  assign wr_data = w_take ? s_axi_wdata : wdata_ff;
  logic wr_tcfg;
  logic [2:0] wr_idx;
  logic wr_ok;
  assign wr_idx = 3'((wr_addr - ebp_pkg::OFS_TIMING0) >> 2);
  assign wr_tcfg = (wr_addr >= ebp_pkg::OFS_TIMING0) && (wr_addr < ebp_pkg::OFS_REQ_ADDR)
                   && (wr_addr[1:0] == 2'b00) && (32'(wr_idx) < NUM_CS);
  assign wr_ok = wr_tcfg || wr_addr == ebp_pkg::OFS_CTRL || wr_addr == ebp_pkg::OFS_REQ_ADDR
                 || wr_addr == ebp_pkg::OFS_REQ_DATA;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awdone_ff <= 1'b0;
      wdone_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= '0;
      bvalid_ff <= 1'b0;
      bresp_ff <= ebp_pkg::RESP_OKAY;
      ctrl_ff <= '0;
      cs_sel_ff <= 2'd0;
      req_addr_ff <= '0;
      req_data_ff <= '0;
      go_ff <= 1'b0;
      for (int i = 0; i < NUM_CS; i++) tcfg_ff[i] <= ebp_pkg::TC_RESET;
    end else begin
      if (aw_take) awaddr_ff <= s_axi_awaddr;
      if (w_take) wdata_ff <= s_axi_wdata;
      awdone_ff <= (awdone_ff || aw_take) && !wr_fire;
      wdone_ff <= (wdone_ff || w_take) && !wr_fire;
      if (start) go_ff <= 1'b0;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? ebp_pkg::RESP_OKAY : ebp_pkg::RESP_SLVERR;
        if (wr_tcfg && !busy) tcfg_ff[wr_idx[1:0]] <= wr_data;
        if (wr_addr == ebp_pkg::OFS_REQ_ADDR && !busy) req_addr_ff <= wr_data[23:0];
        if (wr_addr == ebp_pkg::OFS_REQ_DATA && !busy) req_data_ff <= wr_data[15:0];
        if (wr_addr == ebp_pkg::OFS_CTRL && !busy) begin
          ctrl_ff <= wr_data[3:0];
          cs_sel_ff <= wr_data[ebp_pkg::CTRL_CS_LSB +: 2];
          go_ff <= wr_data[ebp_pkg::CTRL_GO];
        end
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // axi4-lite read channel
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [2:0] rd_idx;
  assign rd_idx = 3'((s_axi_araddr - ebp_pkg::OFS_TIMING0) >> 2);
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == ebp_pkg::OFS_CTRL) begin
      rd_mux = {26'h0, cs_sel_ff, ctrl_ff[3:1], go_ff};
    end else if (s_axi_araddr >= ebp_pkg::OFS_TIMING0 && s_axi_araddr < ebp_pkg::OFS_REQ_ADDR
                 && s_axi_araddr[1:0] == 2'b00 && 32'(rd_idx) < NUM_CS) begin
      rd_mux = tcfg_ff[rd_idx[1:0]];
    end else if (s_axi_araddr == ebp_pkg::OFS_REQ_ADDR) begin
      rd_mux = {8'h00, req_addr_ff};
    end else if (s_axi_araddr == ebp_pkg::OFS_REQ_DATA) begin
      rd_mux = {16'h0000, req_data_ff};
    end else if (s_axi_araddr == ebp_pkg::OFS_STATUS) begin
      rd_mux = {25'h0, ph_ff, 3'h0, busy};
    end else if (s_axi_araddr == ebp_pkg::OFS_RD_DATA) begin
      rd_mux = {16'h0000, rd_data_ff};
    end else begin
      rd_hit = 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= ebp_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_ff) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_hit ? ebp_pkg::RESP_OKAY : ebp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
endmodule // ebp_seq

// ==== tb/ebp_properties.sv ====
/*
  concurrent checks on the external bus pins of the cycle sequencer.
  assumes one clock domain and the pin struct of the package.
*/
`timescale 1ns/100ps
module ebp_properties (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // external bus
  input wire ebp_pkg::ebp_pins_t bus
);
  // all checks share the system clock and reset
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  one_strobe_a: assert property (bus.rd_n || bus.wr_n)
    else $error("read and write strobes low together");
  strobe_in_cs_a: assert property ((!bus.rd_n || !bus.wr_n) |-> bus.cs_n != '1)
    else $error("strobe low without a chip select");
  one_cs_a: assert property ($onehot0(~bus.cs_n))
    else $error("more than one chip select low");
  ale_pulse_a: assert property (bus.ale |=> !bus.ale)
    else $error("latch enable longer than one step");
  ale_addr_a: assert property (bus.ale |-> bus.doe && bus.dout == bus.addr[15:0]
    && bus.rd_n && bus.wr_n)
    else $error("latch enable without address on data lines");
  wr_drive_a: assert property (!bus.wr_n |-> bus.doe)
    else $error("write strobe without driven data");
  rd_float_a: assert property (!bus.rd_n |-> !bus.doe)
    else $error("data lines driven during read");
  addr_hold_a: assert property (!bus.rd_n && $past(!bus.rd_n) |->
    $stable(bus.addr) && $stable(bus.cs_n))
    else $error("address moved during read strobe");
  setup_first_a: assert property ($fell(bus.rd_n) || $fell(bus.wr_n) |->
    $past(bus.cs_n) != '1)
    else $error("strobe without a setup step");
  wdata_stable_a: assert property (!bus.wr_n && $past(!bus.wr_n) |-> $stable(bus.dout))
    else $error("write data moved during strobe");
endmodule // ebp_properties

bind ebp_seq ebp_properties ebp_properties_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus));

// ==== tb/ebp_mem_model.sv ====
/*
  behavioural memory with ready output on the external bus.
  assumes registered sequencer pins; ready polarity and delay from the bench.
*/
`timescale 1ns/100ps
module ebp_mem_model (
  // clock
  input wire logic clk,
  // sequencer pins
  input wire ebp_pkg::ebp_pins_t bus,
  // ready behaviour
  input wire logic rdy_pol,
  input wire logic [3:0] rdy_wait,
  // answers
  output logic [15:0] bus_din,
  output logic ready_pin
);
  logic [15:0] mem [16];
  logic [15:0] last_ff = 16'hA5A5;
  logic [3:0] cnt_ff = 4'h0;
  logic strobe;
  // data only while read is strobed, else inverted residue
  assign strobe = !bus.rd_n || !bus.wr_n;
  assign bus_din = (!bus.rd_n && bus.cs_n != '1) ? mem[bus.addr[3:0]] : ~last_ff;
  assign ready_pin = rdy_pol ~^ (strobe && cnt_ff >= rdy_wait);
  // strobe length count, write capture, residue tracking
  always @(posedge clk) begin
    cnt_ff <= strobe ? cnt_ff + 4'h1 : 4'h0;
    if (!bus.rd_n) last_ff <= bus_din;
    if (!bus.wr_n && bus.cs_n != '1) mem[bus.addr[3:0]] <= bus.dout;
  end
endmodule // ebp_mem_model

// ==== tb/tb.sv ====
/*
  self-checking bench for the bus cycle sequencer: axi4-lite master tasks,
  phase length monitor, a reset check task and one cycle task run per scenario. assumes the memory model.
*/
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0, sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ready_pin, rdy_pol = 1'b1, bhe_seen, stb_seen;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] rdy_wait = 4'h0, cs_seen;
  logic [15:0] bus_din;
  ebp_pkg::ebp_pins_t bus;
  int failures = 0, samples_checked = 0, pre_n, acc_n, post_n;

  ebp_seq ebp_seq_inst (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus, .bus_din, .ready_pin);
  ebp_mem_model ebp_mem_model_inst (.clk, .bus, .rdy_pol, .rdy_wait, .bus_din, .ready_pin);

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // phase length monitor: setup, strobe and hold steps of one cycle
  always @(posedge clk) begin
    if (bus.cs_n != 4'hF) begin
      cs_seen = bus.cs_n;
      if (!bus.rd_n || !bus.wr_n) begin
        acc_n++;
        stb_seen = 1'b1;
        bhe_seen = bus.bhe_n;
      end else if (stb_seen) post_n++;
      else pre_n++;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // reset values and an unmapped place
  task automatic regs_after_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(ebp_pkg::OFS_TIMING0, d, r);
    check(d, ebp_pkg::TC_RESET);
    axi_rd(8'h40, d, r);
    check({d, r}, {32'h0, ebp_pkg::RESP_SLVERR});
    axi_wr(8'h40, 32'h0000_FFFF, r);
    check(r, ebp_pkg::RESP_SLVERR);
  endtask

  // one programmed bus cycle, phase lengths and data judged afterwards
  task automatic run(input int cs, input logic wr, input logic byte_high_enable, input logic [31:0] tc,
      input logic [23:0] a, input logic [15:0] wd, input int pre, input int amin,
      input int amax, input int post);
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_wr(ebp_pkg::OFS_TIMING0 + 8'(4 * cs), tc, r);
    axi_wr(ebp_pkg::OFS_REQ_ADDR, {8'h00, a}, r);
    axi_wr(ebp_pkg::OFS_REQ_DATA, {16'h0, wd}, r);
    pre_n = 0;
    acc_n = 0;
    post_n = 0;
    stb_seen = 1'b0;
    axi_wr(ebp_pkg::OFS_CTRL, 32'(cs << 4) | {29'h0, byte_high_enable, wr, 1'b1}, r);
    n = 0;
    do begin
      axi_rd(ebp_pkg::OFS_STATUS, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 100);
    check(d[0], 1'b0);
    check(pre_n, pre);
    check(32'(acc_n >= amin && acc_n <= amax), 32'h1);
    check(post_n, post);
    check(cs_seen, {28'h0, ~(4'h1 << cs)});
    check(bhe_seen, !byte_high_enable);
    if (!wr) begin
      axi_rd(ebp_pkg::OFS_RD_DATA, d, r);
      check(d, {16'h0, wd});
    end
  endtask

  // watchdog
  initial begin
    #(25 * 20000);
    failures++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    regs_after_reset();
    run(0, 1, 1, 32'h183D, 24'h000003, 16'hBEEF, 8, 1, 1, 3);
    run(0, 0, 0, 32'h183D, 24'h000003, 16'hBEEF, 6, 1, 1, 3);
    run(1, 1, 0, 32'h27C0, 24'h000005, 16'h1234, 1, 32, 32, 0);
    run(1, 0, 1, 32'h27E0, 24'h000005, 16'h1234, 2, 32, 32, 0);
    rdy_wait <= 4'h5;
    run(2, 1, 0, 32'hC040, 24'h000009, 16'h5A5A, 1, 6, 9, 0);
    rdy_wait <= 4'h0;
    rdy_pol <= 1'b0;
    run(3, 0, 0, 32'h14040, 24'h000003, 16'hBEEF, 1, 3, 7, 0);
    tally_and_finish();
  end
endmodule // tb
